// >>> rtl/fault_pkg.sv
// constants for the untranslated-with-identifier fault classifier
// assumes a single translation clock shared by all users
package fault_pkg;

    // ----------------------------------------------------------------
    // request address kind
    // ----------------------------------------------------------------
    localparam logic [1:0] KIND_UNTRANSLATED = 2'h0;

    // ----------------------------------------------------------------
    // fault reason codes
    // ----------------------------------------------------------------
    localparam int         REASON_W          = 4;
    localparam logic [3:0] REASON_NONE       = 4'h0;
    localparam logic [3:0] REASON_ROOT_ABS   = 4'h1;
    localparam logic [3:0] REASON_CTX_ABS    = 4'h2;
    localparam logic [3:0] REASON_CTX_PROG   = 4'h3;
    localparam logic [3:0] REASON_IA_RANGE   = 4'h4;
    localparam logic [3:0] REASON_NO_WRITE   = 4'h5;
    localparam logic [3:0] REASON_NO_READ    = 4'h6;
    localparam logic [3:0] REASON_SL_FETCH   = 4'h7;
    localparam logic [3:0] REASON_ROOT_FETCH = 4'h8;
    localparam logic [3:0] REASON_CTX_FETCH  = 4'h9;
    localparam logic [3:0] REASON_ROOT_RSVD  = 4'hA;

    // ----------------------------------------------------------------
    // condition vector positions, lowest index wins (walk order)
    // ----------------------------------------------------------------
    localparam int COND_N          = 10;
    localparam int C_ROOT_FETCH    = 0;
    localparam int C_ROOT_ABS      = 1;
    localparam int C_ROOT_RSVD     = 2;
    localparam int C_CTX_FETCH     = 3;
    localparam int C_CTX_ABS       = 4;
    localparam int C_CTX_PROG      = 5;
    localparam int C_IA_RANGE      = 6;
    localparam int C_SL_FETCH      = 7;
    localparam int C_NO_WRITE      = 8;
    localparam int C_NO_READ       = 9;

    localparam logic [3:0] COND_REASON [COND_N] = '{
        REASON_ROOT_FETCH, REASON_ROOT_ABS, REASON_ROOT_RSVD, REASON_CTX_FETCH,
        REASON_CTX_ABS, REASON_CTX_PROG, REASON_IA_RANGE, REASON_SL_FETCH,
        REASON_NO_WRITE, REASON_NO_READ
    };
    // root fetch error is qualified like the other 2h..8h reasons
    localparam logic [COND_N-1:0] COND_QUALIFIED = 10'h3F1;

    // ----------------------------------------------------------------
    // address widths
    // ----------------------------------------------------------------
    localparam int ADDR_W  = 64;
    localparam int WIDTH_W = 7;

endpackage

// >>> rtl/fault_priority.sv
// priority selector: picks the first fault met along the walk
// assumes a combinational condition vector from the same clock
`timescale 1ns/100ps
module fault_priority (
    fault_sel_if.selector sel
);
    import fault_pkg::*;

    // ----------------------------------------------------------------
    // lowest set condition wins
    // ----------------------------------------------------------------
    always_comb begin
        sel.any       = 1'b0;
        sel.qualified = 1'b0;
        sel.reason    = REASON_NONE;
        for (int i = COND_N - 1; i >= 0; i--) begin
            if (sel.cond[i]) begin
                sel.any       = 1'b1;
                sel.qualified = COND_QUALIFIED[i];
                sel.reason    = COND_REASON[i];
            end
        end
    end
endmodule // fault_priority

// >>> rtl/fault_sel_if.sv
// carrier between the classifier and its priority selector
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface fault_sel_if;
    import fault_pkg::*;
    logic [COND_N-1:0]   cond;
    logic                any;
    logic                qualified;
    logic [REASON_W-1:0] reason;

    modport selector (input cond, output any, output qualified, output reason);
    modport user     (output cond, input any, input qualified, input reason);
endinterface

// >>> rtl/pasid_untranslated_fault_classifier.sv
// fault classifier for untranslated requests carrying a process identifier
// assumes walk results are presented in the same cycle as req_valid_i
`timescale 1ns/100ps

// Contract
// R1 - only untranslated identifier requests are classified
// R2 - root half not present gives 1h unqualified
// R3 - context entry not present gives 2h qualified
// R4 - misprogrammed context entry gives 3h
// R5 - nested intermediate address over limit gives 4h
// R6 - missing write permission gives 5h
// R7 - missing read permission gives 6h
// R8 - zero-length read to write-only page exempt
// R9 - stage2 lower entry fetch error gives 7h
// R10 - root entry fetch error gives 8h
// R11 - context entry fetch error gives 9h
// R12 - reserved bits in valid root half give Ah
// R13 - every fault blocks with unsupported request status
module pasid_untranslated_fault_classifier (
    // clock and reset
    input  wire logic                        mclk_i,
    input  wire logic                        reset_i,
    // request
    input  wire logic                        req_valid_i,
    input  wire logic                        req_has_pasid_i,
    input  wire logic [1:0]                  addr_kind_field_i,
    input  wire logic                        req_write_i,
    input  wire logic                        req_read_i,
    input  wire logic                        req_atomic_i,
    input  wire logic                        req_zero_length_i,
    // root entry walk
    input  wire logic                        root_fetch_err_i,
    input  wire logic                        use_upper_half_i,
    input  wire logic                        upper_half_valid_i,
    input  wire logic                        low_half_valid_i,
    input  wire logic                        root_rsvd_low_i,
    input  wire logic                        root_rsvd_high_i,
    // context entry walk
    input  wire logic                        ctx_fetch_err_i,
    input  wire logic                        ctx_present_i,
    input  wire logic                        aw_unsupported_i,
    input  wire logic                        type_unsupported_i,
    input  wire logic                        stage2_root_fetch_err_i,
    input  wire logic [fault_pkg::ADDR_W-1:0] process_table_pointer_i,
    input  wire logic                        process_table_fetch_err_i,
    input  wire logic [fault_pkg::WIDTH_W-1:0] host_addr_width_i,
    input  wire logic [fault_pkg::WIDTH_W-1:0] addr_width_field_i,
    // nested translation
    input  wire logic                        nesting_en_i,
    input  wire logic                        ia_valid_i,
    input  wire logic [fault_pkg::ADDR_W-1:0] ia_i,
    input  wire logic [fault_pkg::WIDTH_W-1:0] max_guest_addr_width_i,
    input  wire logic                        sl_next_fetch_err_i,
    // permissions
    input  wire logic                        fl_write_ok_i,
    input  wire logic                        fl_read_ok_i,
    input  wire logic                        sl_write_ok_i,
    input  wire logic                        sl_read_ok_i,
    input  wire logic                        sl_ad_write_ok_i,
    input  wire logic                        sl_entry_read_ok_i,
    input  wire logic                        sl_write_only_i,
    input  wire logic                        zero_length_read_cap_i,
    // verdict
    output logic                             done_o,
    output logic                             bypass_o,
    output logic                             fault_o,
    output logic [fault_pkg::REASON_W-1:0]   fault_reason_o,
    output logic                             fault_qualified_o,
    output logic                             block_ur_o,
    output logic                             forward_o
);
    import fault_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // true when addr needs more than width bits
    function automatic logic addr_over(input logic [ADDR_W-1:0]  addr,
                                       input logic [WIDTH_W-1:0] width);
        if (width >= WIDTH_W'(ADDR_W))
            return 1'b0;
        return (addr >> width) != '0;
    endfunction

    function automatic logic one_hot_at(input logic [COND_N-1:0] v, input int i);
        return v == (COND_N'(1) << i);
    endfunction

    // ----------------------------------------------------------------
    // condition vector
    // ----------------------------------------------------------------
    fault_sel_if sel ();

    logic                applies;
    logic                half_valid;
    logic [WIDTH_W-1:0]  guest_width;
    logic                write_like;
    logic                read_like;
    logic                read_exempt;

    assign applies     = req_has_pasid_i && (addr_kind_field_i == KIND_UNTRANSLATED); // see R1
    assign half_valid  = use_upper_half_i ? upper_half_valid_i : low_half_valid_i;
    assign guest_width = (max_guest_addr_width_i < addr_width_field_i)
                         ? max_guest_addr_width_i : addr_width_field_i;
    assign write_like  = req_write_i || req_atomic_i;
    assign read_like   = req_read_i || req_atomic_i;
    // write-only stage2 pages may still see zero-length reads
    assign read_exempt = zero_length_read_cap_i && req_zero_length_i && req_read_i
                         && !req_atomic_i && sl_write_only_i; // see R8

    always_comb begin
        sel.cond               = '0;
        sel.cond[C_ROOT_FETCH] = root_fetch_err_i; // see R10
        sel.cond[C_ROOT_ABS]   = !half_valid; // see R2
        sel.cond[C_ROOT_RSVD]  = (low_half_valid_i && root_rsvd_low_i)
                                 || (upper_half_valid_i && root_rsvd_high_i); // see R12
        sel.cond[C_CTX_FETCH]  = ctx_fetch_err_i; // see R11
        sel.cond[C_CTX_ABS]    = !ctx_present_i; // see R3
        sel.cond[C_CTX_PROG]   = aw_unsupported_i || type_unsupported_i
                                 || (nesting_en_i && stage2_root_fetch_err_i)
                                 || addr_over(process_table_pointer_i, host_addr_width_i)
                                 || process_table_fetch_err_i; // see R4
        sel.cond[C_IA_RANGE]   = nesting_en_i && ia_valid_i
                                 && addr_over(ia_i, guest_width); // see R5
        sel.cond[C_SL_FETCH]   = sl_next_fetch_err_i; // see R9
        sel.cond[C_NO_WRITE]   = write_like && (!fl_write_ok_i
                                 || (nesting_en_i && (!sl_write_ok_i || !sl_ad_write_ok_i))); // see R6
        sel.cond[C_NO_READ]    = read_like && !read_exempt && (!fl_read_ok_i
                                 || (nesting_en_i && (!sl_read_ok_i || !sl_entry_read_ok_i))); // see R7
    end

    fault_priority u_priority (
        .sel (sel.selector)
    );

    // ----------------------------------------------------------------
    // verdict registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            done_o   <= 1'b0;
            bypass_o <= 1'b0;
        end else begin
            done_o   <= req_valid_i;
            bypass_o <= req_valid_i && !applies; // see R1
        end
    end

    // a faulted request never reaches memory
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            fault_o           <= 1'b0;
            fault_reason_o    <= REASON_NONE;
            fault_qualified_o <= 1'b0;
            block_ur_o        <= 1'b0;
            forward_o         <= 1'b0;
        end else if (req_valid_i) begin
            fault_o           <= applies && sel.any;
            fault_reason_o    <= applies ? sel.reason : REASON_NONE;
            fault_qualified_o <= applies && sel.qualified;
            block_ur_o        <= applies && sel.any; // see R13
            forward_o         <= !(applies && sel.any); // see R13
        end else begin
            fault_o    <= 1'b0;
            block_ur_o <= 1'b0;
            forward_o  <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_NOT_APPLIED: assert property (@(posedge mclk_i) disable iff (reset_i) // see R1
        req_valid_i && !applies |=> bypass_o && !fault_o && forward_o)
        else $error("request outside this table was classified");
    AST_ROOT_ABSENT: assert property (@(posedge mclk_i) disable iff (reset_i) // see R2
        req_valid_i && applies && !root_fetch_err_i && !half_valid
        |=> fault_o && fault_reason_o == REASON_ROOT_ABS && !fault_qualified_o)
        else $error("absent root half not reported as 1h");
    AST_CTX_ABSENT: assert property (@(posedge mclk_i) disable iff (reset_i) // see R3
        req_valid_i && applies && one_hot_at(sel.cond, C_CTX_ABS)
        |=> fault_reason_o == REASON_CTX_ABS && fault_qualified_o)
        else $error("absent context entry not reported as 2h");
    AST_CTX_PROG: assert property (@(posedge mclk_i) disable iff (reset_i) // see R4
        req_valid_i && applies && half_valid && ctx_present_i && !root_fetch_err_i
        && !ctx_fetch_err_i && !sel.cond[C_ROOT_RSVD] && aw_unsupported_i
        |=> fault_reason_o == REASON_CTX_PROG)
        else $error("misprogrammed context entry not reported as 3h");
    AST_IA_RANGE: assert property (@(posedge mclk_i) disable iff (reset_i) // see R5
        req_valid_i && applies && one_hot_at(sel.cond, C_IA_RANGE)
        |=> fault_o && fault_reason_o == REASON_IA_RANGE)
        else $error("intermediate address overflow not reported as 4h");
    AST_NO_WRITE: assert property (@(posedge mclk_i) disable iff (reset_i) // see R6
        req_valid_i && applies && sel.cond[C_NO_WRITE-1:0] == '0 && write_like && !fl_write_ok_i
        |=> fault_reason_o == REASON_NO_WRITE)
        else $error("write without permission not reported as 5h");
    AST_NO_READ: assert property (@(posedge mclk_i) disable iff (reset_i) // see R7
        req_valid_i && applies && one_hot_at(sel.cond, C_NO_READ)
        |=> fault_reason_o == REASON_NO_READ && block_ur_o)
        else $error("read without permission not reported as 6h");
    AST_ZLR_EXEMPT: assert property (@(posedge mclk_i) disable iff (reset_i) // see R8
        req_valid_i && applies && read_exempt |=> fault_reason_o != REASON_NO_READ)
        else $error("exempt zero-length read reported as 6h");
    AST_SL_FETCH: assert property (@(posedge mclk_i) disable iff (reset_i) // see R9
        req_valid_i && applies && one_hot_at(sel.cond, C_SL_FETCH)
        |=> fault_reason_o == REASON_SL_FETCH)
        else $error("stage2 fetch error not reported as 7h");
    AST_ROOT_FETCH: assert property (@(posedge mclk_i) disable iff (reset_i) // see R10
        req_valid_i && applies && root_fetch_err_i
        |=> fault_o && fault_reason_o == REASON_ROOT_FETCH && fault_qualified_o)
        else $error("root fetch error not reported as 8h");
    AST_CTX_FETCH: assert property (@(posedge mclk_i) disable iff (reset_i) // see R11
        req_valid_i && applies && one_hot_at(sel.cond, C_CTX_FETCH)
        |=> fault_reason_o == REASON_CTX_FETCH && !fault_qualified_o)
        else $error("context fetch error not reported as 9h");
    AST_ROOT_RSVD: assert property (@(posedge mclk_i) disable iff (reset_i) // see R12
        req_valid_i && applies && one_hot_at(sel.cond, C_ROOT_RSVD)
        |=> fault_reason_o == REASON_ROOT_RSVD)
        else $error("root reserved bits not reported as Ah");
    AST_BLOCKED: assert property (@(posedge mclk_i) disable iff (reset_i) // see R13
        fault_o |-> block_ur_o && !forward_o && done_o)
        else $error("faulted request not blocked");
    AST_ONE_VERDICT: assert property (@(posedge mclk_i) disable iff (reset_i) // see R13
        req_valid_i |=> done_o && (block_ur_o != forward_o))
        else $error("request did not get exactly one verdict");
    AST_IDLE_QUIET: assert property (@(posedge mclk_i) disable iff (reset_i) // see R13
        !req_valid_i |=> !done_o && !fault_o && !block_ur_o && !forward_o && !bypass_o)
        else $error("verdict pulse without a request");
    AST_IA_GATED: assert property (@(posedge mclk_i) disable iff (reset_i) // see R5
        req_valid_i && applies && !(nesting_en_i && ia_valid_i)
        |=> fault_reason_o != REASON_IA_RANGE)
        else $error("range fault without a nested intermediate address");
endmodule // pasid_untranslated_fault_classifier

// >>> testbench/pasid_untranslated_fault_classifier_tb_top.sv
// self-checking bench for the untranslated-with-identifier fault classifier
// assumes one 100 MHz clock and the requester model on the request side
`timescale 1ns/100ps
`include "req_types.svh"
module pasid_untranslated_fault_classifier_tb_top;
    import fault_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic       mclk_i, reset_i, fire, rq_valid;
    req_t       cfg, rq;
    logic       done_o, bypass_o, fault_o, fault_qualified_o, block_ur_o, forward_o;
    logic [3:0] fault_reason_o;
    int         miscompares, check_count;
    // {bypass, reason} per case: clean, 8h, 1h x2, Ah x2, 9h, 2h, 3h x5, range edges,
    // 7h, 5h x3, 6h x3, exempt/6h, two bypasses, nesting off, priority, ia not valid
    localparam logic [4:0] EXP [31] = '{5'h00, 5'h08, 5'h01, 5'h01, 5'h0A, 5'h0A,
        5'h09, 5'h02, 5'h03, 5'h03, 5'h03, 5'h03, 5'h03, 5'h00, 5'h04, 5'h00, 5'h04,
        5'h07, 5'h05, 5'h05, 5'h05, 5'h06, 5'h06, 5'h06, 5'h00, 5'h06, 5'h10, 5'h10,
        5'h00, 5'h08, 5'h00};

    requester_model req_src (.mclk_i(mclk_i), .reset_i(reset_i), .fire_i(fire), .cfg_i(cfg),
        .req_valid_o(rq_valid), .req_o(rq));

    pasid_untranslated_fault_classifier uut (.mclk_i(mclk_i), .reset_i(reset_i),
        .req_valid_i(rq_valid), .req_has_pasid_i(rq.has_pasid), .addr_kind_field_i(rq.kind),
        .req_write_i(rq.wr), .req_read_i(rq.rd), .req_atomic_i(rq.at),
        .req_zero_length_i(rq.zl), .root_fetch_err_i(rq.root_err),
        .use_upper_half_i(rq.use_up), .upper_half_valid_i(rq.up_ok),
        .low_half_valid_i(rq.lo_ok), .root_rsvd_low_i(rq.rsv_lo), .root_rsvd_high_i(rq.rsv_hi),
        .ctx_fetch_err_i(rq.ctx_err), .ctx_present_i(rq.ctx_ok), .aw_unsupported_i(rq.aw_bad),
        .type_unsupported_i(rq.ty_bad), .stage2_root_fetch_err_i(rq.s2_err),
        .process_table_pointer_i(rq.ptp), .process_table_fetch_err_i(rq.pt_err),
        .host_addr_width_i(rq.host_addr_width), .addr_width_field_i(rq.awf), .nesting_en_i(rq.nest),
        .ia_valid_i(rq.ia_ok), .ia_i(rq.ia), .max_guest_addr_width_i(rq.max_guest_addr_width),
        .sl_next_fetch_err_i(rq.sl_err), .fl_write_ok_i(rq.fl_w), .fl_read_ok_i(rq.fl_r),
        .sl_write_ok_i(rq.sl_w), .sl_read_ok_i(rq.sl_r), .sl_ad_write_ok_i(rq.sl_ad),
        .sl_entry_read_ok_i(rq.sl_ent), .sl_write_only_i(rq.sl_wo),
        .zero_length_read_cap_i(rq.zero_length_read_cap), .done_o(done_o), .bypass_o(bypass_o),
        .fault_o(fault_o), .fault_reason_o(fault_reason_o),
        .fault_qualified_o(fault_qualified_o), .block_ur_o(block_ur_o), .forward_o(forward_o));

    // ----------------------------------------------------------------
    // case table: case 0 is a clean request, each other case changes a walk step or request field of it
    // ----------------------------------------------------------------
    function automatic req_t build(input int i);
        req_t c;
        c.has_pasid = (i != 26);
        c.kind = (i == 27) ? 2'h1 : KIND_UNTRANSLATED;
        c.wr = i inside {18, 19, 20};
        c.rd = !(i inside {18, 19});
        c.at = i inside {20, 23};
        c.zl = i inside {24, 25};
        c.root_err = i inside {1, 29};
        c.use_up = (i == 3);
        c.up_ok = (i == 5);
        c.lo_ok = (i != 2);
        c.rsv_lo = (i == 4);
        c.rsv_hi = (i == 5);
        c.ctx_err = (i == 6);
        c.ctx_ok = !(i inside {7, 29});
        c.aw_bad = (i == 8);
        c.ty_bad = (i == 9);
        c.s2_err = (i == 10);
        c.pt_err = (i == 11);
        // pointer and address edges sit on either side of a 48-bit limit
        c.ptp = (i == 12) ? 64'h0001_0000_0000_0000 : (i == 13) ? 64'h0000_FFFF_FFFF_FFFF
              : 64'h0000_0000_0000_2000;
        c.host_addr_width = 7'h30;
        c.awf = 7'h30;
        c.max_guest_addr_width = (i == 16) ? 7'h27 : 7'h30;
        c.nest = (i != 28);
        c.ia_ok = (i != 30);
        c.ia = (i inside {14, 28, 30}) ? 64'h0001_0000_0000_0000
             : (i == 15) ? 64'h0000_FFFF_FFFF_FFFF
             : (i == 16) ? 64'h0000_0080_0000_0000 : 64'h0000_0000_0000_1000;
        c.sl_err = (i == 17);
        c.fl_w = (i != 18);
        c.fl_r = (i != 21);
        c.sl_w = (i != 20);
        c.sl_r = !(i inside {23, 24, 25, 28});
        c.sl_ad = (i != 19);
        c.sl_ent = (i != 22);
        c.sl_wo = i inside {24, 25};
        c.zero_length_read_cap = (i == 24);
        return c;
    endfunction

    // ----------------------------------------------------------------
    // compare and access tasks
    // ----------------------------------------------------------------
    task automatic check_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_reason(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_verdict(input int i);
        logic [3:0] r;
        logic       flt;
        r = EXP[i][3:0];
        flt = (r != 4'h0);
        check_flag(done_o, 1'b1);
        check_flag(fault_o, flt);
        check_flag(block_ur_o, flt);
        check_flag(forward_o, !flt);
        check_flag(bypass_o, EXP[i][4]);
        check_reason(fault_reason_o, r);
        check_flag(fault_qualified_o, (r >= 4'h2) && (r <= 4'h8));
    endtask

    task automatic run_one(input int i);
        @(posedge mclk_i);
        fire <= 1'b1;
        cfg  <= build(i);
        @(posedge mclk_i);
        fire <= 1'b0;
        @(posedge mclk_i);
        #1;
        check_verdict(i);
        @(posedge mclk_i);
        #1;
        check_flag(done_o, 1'b0);
        check_reason(fault_reason_o, EXP[i][3:0]);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    initial begin
        repeat (3000) @(posedge mclk_i);
        miscompares++;
        report_and_stop();
    end

    initial begin
        miscompares = 0;
        check_count = 0;
        reset_i = 1'b1;
        fire = 1'b0;
        cfg = build(0);
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1;
        check_flag(done_o, 1'b0);
        check_reason(fault_reason_o, 4'h0);
        for (int i = 0; i < 31; i++) run_one(i);
        // back to back: write fault then read fault on consecutive cycles
        @(posedge mclk_i);
        fire <= 1'b1;
        cfg  <= build(18);
        @(posedge mclk_i);
        cfg  <= build(21);
        @(posedge mclk_i);
        fire <= 1'b0;
        #1;
        check_verdict(18);
        @(posedge mclk_i);
        #1;
        check_verdict(21);
        // reset in mid-run clears the held reason
        @(posedge mclk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1;
        check_reason(fault_reason_o, 4'h0);
        run_one(7);
        report_and_stop();
    end
endmodule // pasid_untranslated_fault_classifier_tb_top

// >>> testbench/req_types.svh
// request and walk fields that the requester model presents to the classifier
// assumes fault_pkg is compiled before any file that includes this one
`ifndef REQ_TYPES_SVH
`define REQ_TYPES_SVH
typedef struct packed {
    logic                          has_pasid;
    logic [1:0]                    kind;
    logic                          wr, rd, at, zl;
    logic                          root_err, use_up, up_ok, lo_ok, rsv_lo, rsv_hi;
    logic                          ctx_err, ctx_ok, aw_bad, ty_bad, s2_err, pt_err;
    logic [fault_pkg::ADDR_W-1:0]  ptp;
    logic [fault_pkg::WIDTH_W-1:0] host_addr_width, awf, max_guest_addr_width;
    logic                          nest, ia_ok, sl_err;
    logic [fault_pkg::ADDR_W-1:0]  ia;
    logic                          fl_w, fl_r, sl_w, sl_r, sl_ad, sl_ent, sl_wo, zero_length_read_cap;
} req_t;
`endif

// >>> testbench/requester_model.sv
// requester model: presents one request per rising clock edge that samples fire_i high, scrambles idle lines
// assumes the bench drives fire_i and cfg_i at the rising edge
`timescale 1ns/100ps
`include "req_types.svh"
module requester_model (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic reset_i,
    // bench side
    input  wire logic fire_i,
    input  wire req_t cfg_i,
    // classifier side
    output logic      req_valid_o,
    output req_t      req_o
);
    import fault_pkg::*;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            req_valid_o <= 1'b0;
            req_o       <= '0;
        end else if (fire_i) begin
            req_valid_o <= 1'b1;
            req_o       <= cfg_i;
        end else begin
            req_valid_o <= 1'b0;
            // idle lines toggle so a stale walk result is never trusted
            req_o       <= ~req_o;
        end
    end
endmodule // requester_model
